// ==== hdl/drsc_pkg.sv ====
// Package for the dual rheostat serial command unit
package drsc_pkg;

    // ------------------------------------------------------------
    // Frame layout
    // ------------------------------------------------------------
    localparam int FRAME_BITS = 24;
    localparam int OPC_MSB = 23;
    localparam int OPC_LSB = 20;
    localparam int ADR_MSB = 19;
    localparam int ADR_LSB = 16;
    localparam int DAT_MSB = 15;
    localparam int WIPER_BITS = 10;
    localparam int NV_DEPTH = 16;

    // ------------------------------------------------------------
    // Wiper codes
    // ------------------------------------------------------------
    localparam logic [9:0] WIPER_FULL = 10'h3ff;
    localparam logic [9:0] WIPER_MID = 10'h200;
    localparam logic [9:0] WIPER_ONE = 10'h001;
    localparam logic [9:0] WIPER_ZERO = 10'h000;
    localparam logic [15:0] NV_MID = 16'h0200;
    // Factory word in the reserved slot, arbitrary value
    localparam logic [15:0] NV_FACTORY = 16'h0000;
    localparam logic [3:0] NV_RESERVED = 4'hf;
    localparam logic [3:0] NV_USER_LO = 4'h2;
    localparam logic [4:0] BIT_CNT_MAX = 5'h18;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 250;
    localparam int SAVE_MS = 25;
    localparam int RESTORE_US = 1;
    localparam int SAVE_CYCLES = SAVE_MS * 1000 * CLK_MHZ;
    localparam int RESTORE_CYCLES = RESTORE_US * CLK_MHZ;

    // ------------------------------------------------------------
    // Opcodes
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        OP_NOP = 4'h0, OP_RESTORE = 4'h1, OP_SAVE = 4'h2,
        OP_NVWRITE = 4'h3, OP_SHR = 4'h4, OP_SHR_ALL = 4'h5,
        OP_DEC = 4'h6, OP_DEC_ALL = 4'h7, OP_RELOAD_ALL = 4'h8,
        OP_READ_NV = 4'h9, OP_READ_WIPER = 4'ha, OP_WRITE = 4'hb,
        OP_SHL = 4'hc, OP_SHL_ALL = 4'hd, OP_INC = 4'he,
        OP_INC_ALL = 4'hf
    } drsc_op_t;

    typedef struct packed {
        drsc_op_t opcode;
        logic [3:0] addr;
        logic [15:0] data;
    } drsc_frame_t;

endpackage

// ==== hdl/drsc_unit.sv ====
// Serial command unit for a dual programmable rheostat
// Notes on behaviour
// - Frame is opcode, address, sixteen data bits
// - Bits captured on rising clock, MSB first
// - Command acts when chip select rises
// - Opcode 0 changes no wiper or store, clears read state
// - Opcode 1 restores selected wiper, read state
// - Opcode 2 saves selected wiper to store
// - Opcode 3 writes data word to store
// - Preset slots keep all sixteen bits, reload uses low ten
// - Opcodes 4,5 right shift, saturate at zero
// - Opcodes 6,7 decrement, floor at zero
// - Opcodes 14,15 increment, ceiling all ones
// - Opcodes 12,13 double, saturate at 1023
// - Zero shifts to one, midscale up fullscale
// - Opcode 8 reloads both wipers
// - Opcodes 9,10 load readback into data field
// - Opcode 11 writes D9..D0 to wiper
// - Otherwise output repeats last 24 bits
// - Readback appears in the following frame
// - Step and shift opcodes ignore data
// - Power-up loads wipers; preset slots hold midscale
// - Save takes 25 ms, locked, ready shows
// - Preset low forces midscale, release while idle reloads
// - Write-protect blocks changes except restores and reloads
// - Serial output released while select high
// - Slot 15 read-only; user slots 2..14
`timescale 1ns/100ps
module drsc_unit
    import drsc_pkg::*;
#(
    parameter int SaveCycles = SAVE_CYCLES,
    parameter int RestoreCycles = RESTORE_CYCLES
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic sclk,
    input wire logic sdi,
    input wire logic cs_n,
    input wire logic preset_strobe_n,
    input wire logic write_protect_n,
    output logic sdo_o,
    output logic sdo_oe,
    output logic rdy_o,
    output logic rdy_oe,
    output logic [9:0] channel1_wiper_terminal,
    output logic [9:0] channel2_wiper_terminal,
    output logic read_power_state
);

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic [4:0] sync1Q, sync2Q;
    logic sclkPrevQ, csPrevQ;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sync1Q <= 5'h07;
            sync2Q <= 5'h07;
            sclkPrevQ <= 1'b0;
            csPrevQ <= 1'b1;
        end else begin
            sync1Q <= {sclk, sdi, cs_n, preset_strobe_n, write_protect_n};
            sync2Q <= sync1Q;
            sclkPrevQ <= sync2Q[4];
            csPrevQ <= sync2Q[2];
        end
    end
    wire logic sclkS = sync2Q[4];
    wire logic sdiS = sync2Q[3];
    wire logic csS = sync2Q[2];
    wire logic presetS = sync2Q[1];
    wire logic wpS = sync2Q[0];
    wire logic sclkRise = sclkS && !sclkPrevQ;
    wire logic sclkFall = !sclkS && sclkPrevQ;
    wire logic csRise = csS && !csPrevQ;

    // ------------------------------------------------------------
    // Shift register and serial output
    // ------------------------------------------------------------
    typedef enum {ST_BOOT, ST_IDLE, ST_SAVE, ST_RESTORE} drsc_state_t;
    drsc_state_t stateQ;
    logic [23:0] shiftQ;
    logic sdoQ;
    logic [4:0] bitCntQ;
    wire logic busy = (stateQ != ST_IDLE);
    wire logic locked = (stateQ == ST_SAVE);
    drsc_frame_t frame;
    assign frame = drsc_frame_t'(shiftQ);

    logic [15:0] nvMem [NV_DEPTH];
    logic [9:0] wiperQ [2];
    logic loadRead;
    logic [15:0] readWord;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            shiftQ <= '0;
            sdoQ <= 1'b1;
            bitCntQ <= '0;
        end else if (loadRead) begin
            shiftQ[DAT_MSB:0] <= readWord;
        end else if (!csS && !locked && sclkRise) begin
            shiftQ <= {shiftQ[22:0], sdiS};
            if (bitCntQ != BIT_CNT_MAX)
                bitCntQ <= bitCntQ + 5'h01;
        end else if (!csS && sclkFall) begin
            sdoQ <= shiftQ[FRAME_BITS-1];
        end else if (csS) begin
            bitCntQ <= '0;
            sdoQ <= shiftQ[FRAME_BITS-1];
        end
    end
    // Open drain: drive only low, released while deselected
    assign sdo_o = 1'b0;
    assign sdo_oe = !csS && !sdoQ;

    // ------------------------------------------------------------
    // Wiper arithmetic
    // ------------------------------------------------------------
    function automatic logic [9:0] stepOp(drsc_op_t op, logic [9:0] v);
        logic [9:0] r;
        r = v;
        unique case (op)
            OP_SHR, OP_SHR_ALL: r = v >> 1;
            OP_DEC, OP_DEC_ALL:
                r = (v == WIPER_ZERO) ? v : v - WIPER_ONE;
            OP_INC, OP_INC_ALL:
                r = (v == WIPER_FULL) ? v : v + WIPER_ONE;
            OP_SHL, OP_SHL_ALL: begin
                if (v == WIPER_ZERO) r = WIPER_ONE;
                else if (v >= WIPER_MID) r = WIPER_FULL;
                else r = v << 1;
            end
            default: r = v;
        endcase
        return r;
    endfunction

    wire drsc_op_t op = frame.opcode;
    wire logic ch = frame.addr[0];
    wire logic [3:0] nvAddr = frame.addr;
    wire logic doCmd = csRise && !busy;
    wire logic modOk = wpS;
    wire logic isStep = (op == OP_SHR) || (op == OP_DEC) ||
        (op == OP_INC) || (op == OP_SHL);
    wire logic isStepAll = (op == OP_SHR_ALL) || (op == OP_DEC_ALL) ||
        (op == OP_INC_ALL) || (op == OP_SHL_ALL);
    wire logic nvWrOk = (nvAddr != NV_RESERVED);
    assign readWord = (op == OP_READ_NV) ? nvMem[nvAddr] :
        {6'h00, wiperQ[ch]};
    assign loadRead = doCmd &&
        ((op == OP_READ_NV) || (op == OP_READ_WIPER));

    // ------------------------------------------------------------
    // Control state machine
    // ------------------------------------------------------------
    logic [31:0] timerQ;
    logic presetPrevQ, reloadAllQ, saveChQ, readPwrQ;
    logic [3:0] saveAddrQ;
    logic [15:0] saveDataQ;
    wire logic presetRise = presetS && !presetPrevQ;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            stateQ <= ST_BOOT;
            timerQ <= '0;
            presetPrevQ <= 1'b1;
            reloadAllQ <= 1'b1;
            saveChQ <= 1'b0;
            saveAddrQ <= '0;
            saveDataQ <= '0;
            readPwrQ <= 1'b0;
        end else begin
            presetPrevQ <= presetS;
            unique case (stateQ)
                ST_BOOT: begin
                    reloadAllQ <= 1'b1;
                    timerQ <= 32'(RestoreCycles);
                    stateQ <= ST_RESTORE;
                end
                ST_IDLE: begin
                    if (presetRise) begin
                        reloadAllQ <= 1'b1;
                        timerQ <= 32'(RestoreCycles);
                        stateQ <= ST_RESTORE;
                    end else if (doCmd) begin
                        readPwrQ <= (op == OP_RESTORE);
                        if (op == OP_RESTORE || op == OP_RELOAD_ALL) begin
                            reloadAllQ <= (op == OP_RELOAD_ALL);
                            saveChQ <= ch;
                            timerQ <= 32'(RestoreCycles);
                            stateQ <= ST_RESTORE;
                        end else if (modOk && (op == OP_SAVE ||
                            (op == OP_NVWRITE && nvWrOk))) begin
                            saveAddrQ <= (op == OP_SAVE) ? {3'h0, ch} : nvAddr;
                            saveDataQ <= (op == OP_SAVE) ?
                                {6'h00, wiperQ[ch]} : frame.data;
                            timerQ <= 32'(SaveCycles);
                            stateQ <= ST_SAVE;
                        end
                    end
                end
                ST_SAVE, ST_RESTORE: begin
                    if (timerQ <= 32'h1)
                        stateQ <= ST_IDLE;
                    else
                        timerQ <= timerQ - 32'h1;
                end
            endcase
        end
    end
    assign read_power_state = readPwrQ;
    // Ready is high when idle with preset high; open drain pulls low while busy or preset low
    assign rdy_o = 1'b0;
    assign rdy_oe = busy || !presetS;

    // ------------------------------------------------------------
    // Store and wipers
    // ------------------------------------------------------------
    wire logic saveDone = (stateQ == ST_SAVE) && (timerQ <= 32'h1);
    wire logic restDone = (stateQ == ST_RESTORE) && (timerQ <= 32'h1);

    // Power-on store: midscale presets, other slots blank
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < NV_DEPTH; i++) begin
                nvMem[i] <= (i < int'(NV_USER_LO)) ?
                    NV_MID : NV_FACTORY;
            end
        end else if (saveDone) begin
            nvMem[saveAddrQ] <= saveDataQ;
        end
    end

    generate
        for (genvar c = 0; c < 2; c++) begin : g_wiper
            localparam logic ChIdx = 1'(c);
            wire logic sel = isStepAll || (isStep && ch == ChIdx);
            always_ff @(posedge mclk or negedge rst_n) begin
                if (!rst_n) begin
                    wiperQ[c] <= WIPER_MID;
                end else if (!presetS) begin
                    wiperQ[c] <= WIPER_MID;
                end else if (restDone && (reloadAllQ || saveChQ == ChIdx)) begin
                    wiperQ[c] <= nvMem[c][9:0];
                end else if (doCmd && modOk) begin
                    if (op == OP_WRITE && ch == ChIdx)
                        wiperQ[c] <= frame.data[9:0];
                    else if (sel)
                        wiperQ[c] <= stepOp(op, wiperQ[c]);
                end
            end
        end
    endgenerate
    assign channel1_wiper_terminal = wiperQ[0];
    assign channel2_wiper_terminal = wiperQ[1];

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    sdo_release_a: assert property (csS |-> !sdo_oe)
        else $error("serial output driven while deselected");
    busy_freeze_a: assert property (
        busy && presetS && !restDone
        |=> $stable(wiperQ[0]) && $stable(wiperQ[1]))
        else $error("wiper changed while busy");
    wp_block_a: assert property (
        doCmd && !wpS && op == OP_WRITE && presetS
        |=> $stable(wiperQ[ch]))
        else $error("write passed write protect");
    wp_nv_a: assert property (
        doCmd && !wpS && op == OP_NVWRITE
        |=> !locked)
        else $error("store write passed write protect");
    preset_mid_a: assert property (
        !presetS
        |=> wiperQ[0] == WIPER_MID && wiperQ[1] == WIPER_MID)
        else $error("preset did not force midscale");
    preset_reload_a: assert property (
        presetRise && stateQ == ST_IDLE
        |=> stateQ == ST_RESTORE && reloadAllQ)
        else $error("preset release did not reload");
    boot_restore_a: assert property (
        stateQ == ST_BOOT
        |=> stateQ == ST_RESTORE && reloadAllQ)
        else $error("power-up reload not started");
    restore_load_a: assert property (
        restDone && reloadAllQ && presetS
        |=> wiperQ[1] == nvMem[1][9:0])
        else $error("reload did not copy the store");
    rd_state_a: assert property (
        doCmd && !presetRise && op == OP_RESTORE
        |=> read_power_state)
        else $error("restore did not enter read state");
    save_start_a: assert property (
        doCmd && wpS && !presetRise && op == OP_SAVE
        |=> stateQ == ST_SAVE && rdy_oe)
        else $error("save did not start");
    lock_shift_a: assert property (
        locked
        |=> $stable(shiftQ))
        else $error("shift register moved during save");
    slot_guard_a: assert property (
        doCmd && op == OP_NVWRITE && nvAddr == NV_RESERVED
        |=> !locked)
        else $error("reserved slot accepted a write");
    wr_load_a: assert property (
        doCmd && wpS && presetS && op == OP_WRITE && !ch
        |=> wiperQ[0] == frame.data[9:0])
        else $error("direct write not loaded");
    inc_sat_a: assert property (
        doCmd && wpS && presetS && op == OP_INC_ALL &&
        wiperQ[1] == WIPER_FULL |=> wiperQ[1] == WIPER_FULL)
        else $error("increment passed full scale");
    inc_step_a: assert property (
        doCmd && wpS && presetS && op == OP_INC_ALL &&
        wiperQ[0] != WIPER_FULL
        |=> wiperQ[0] == $past(wiperQ[0]) + WIPER_ONE)
        else $error("increment missed one step");
    dec_floor_a: assert property (
        doCmd && wpS && presetS && op == OP_DEC_ALL &&
        wiperQ[0] == WIPER_ZERO |=> wiperQ[0] == WIPER_ZERO)
        else $error("decrement went below zero");
    dec_step_a: assert property (
        doCmd && wpS && presetS && op == OP_DEC_ALL &&
        wiperQ[1] != WIPER_ZERO
        |=> wiperQ[1] == $past(wiperQ[1]) - WIPER_ONE)
        else $error("decrement missed one step");
    shr_half_a: assert property (
        doCmd && wpS && presetS && op == OP_SHR_ALL
        |=> wiperQ[1] == ($past(wiperQ[1]) >> 1))
        else $error("right shift not halved");
    shl_zero_a: assert property (
        doCmd && wpS && presetS && wiperQ[0] == WIPER_ZERO &&
        (op == OP_SHL_ALL || (op == OP_SHL && !ch))
        |=> wiperQ[0] == WIPER_ONE)
        else $error("left shift of zero not one");
    nop_hold_a: assert property (
        doCmd && presetS && op == OP_NOP
        |=> $stable(wiperQ[0]) && $stable(wiperQ[1]))
        else $error("no-op changed a wiper");

    save_cov_c: cover property (doCmd && op == OP_SAVE ##1 busy);
    frame_cov_c: cover property (csRise && bitCntQ == BIT_CNT_MAX);
    read_cov_c: cover property (loadRead);
    write_cov_c: cover property (doCmd && wpS && op == OP_WRITE);
    preset_cov_c: cover property (presetRise);

endmodule // drsc_unit

// ==== test/drsc_host_model.sv ====
// Serial host model that clocks frames into the command unit
`timescale 1ns/100ps
module drsc_host_model
    import drsc_pkg::*;
(
    input wire logic mclk,
    input wire logic sdoLine,
    output logic sclk,
    output logic sdi,
    output logic cs_n
);
    // ------------------------------------------------------------
    // Link timing, 48 ns period aligned to mclk
    // ------------------------------------------------------------
    initial begin
        sclk = 1'b0;
        sdi = 1'b0;
        cs_n = 1'b1;
    end

    task automatic half();
        repeat (6) @(posedge mclk);
        #1;
    endtask

    // ------------------------------------------------------------
    // One whole frame, returned bits sampled on rising sclk
    // ------------------------------------------------------------
    task automatic xfer(input drsc_frame_t f, output logic [23:0] rx);
        cs_n = 1'b0;
        for (int i = FRAME_BITS - 1; i >= 0; i--) begin
            sdi = f[i];
            half();
            sclk = 1'b1;
            rx[i] = sdoLine;
            half();
            sclk = 1'b0;
        end
        half();
        cs_n = 1'b1;
        // Stale data line must not look valid
        sdi = ~sdi;
    endtask
endmodule // drsc_host_model

// ==== test/test_drsc_unit.sv ====
// Self-checking bench for the dual rheostat serial command unit
`timescale 1ns/100ps
module test_drsc_unit;
    import drsc_pkg::*;
    // ------------------------------------------------------------
    // Design, host and clock
    // ------------------------------------------------------------
    logic mclk, rst_n, presetN, wpN, sdoO, sdoOe, rdyO, rdyOe, rdState;
    logic [9:0] w1, w2;
    logic [23:0] rx;
    wire logic sclk, sdi, cs_n;
    wire logic sdoLine = sdoOe ? 1'b0 : 1'b1;
    int errTotal, checkCount, cycles;

    drsc_unit #(.SaveCycles(600), .RestoreCycles(10)) u_dut (
        .mclk(mclk), .rst_n(rst_n), .sclk(sclk), .sdi(sdi), .cs_n(cs_n),
        .preset_strobe_n(presetN), .write_protect_n(wpN),
        .sdo_o(sdoO), .sdo_oe(sdoOe), .rdy_o(rdyO), .rdy_oe(rdyOe),
        .channel1_wiper_terminal(w1), .channel2_wiper_terminal(w2),
        .read_power_state(rdState));
    drsc_host_model u_host (.mclk(mclk), .sdoLine(sdoLine), .sclk(sclk),
        .sdi(sdi), .cs_n(cs_n));

    always #2 mclk = ~mclk;

    always @(posedge mclk) begin
        cycles++;
        if (cycles == 60000) begin
            errTotal++;
            completeRun();
        end
    end

    // ------------------------------------------------------------
    // Access and compare tasks
    // ------------------------------------------------------------
    task automatic completeRun();
        if (errTotal == 0 && checkCount > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chkW(input logic [9:0] got, input logic [9:0] exp);
        checkCount++;
        if (got !== exp) begin
            errTotal++;
            $display("CHECK FAILED %0t value %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chkF(input logic [23:0] got, input logic [23:0] exp);
        checkCount++;
        if (got !== exp) begin
            errTotal++;
            $display("CHECK FAILED %0t frame %h exp %h", $time, got, exp);
        end
    endtask

    task automatic send(input drsc_op_t op, input logic [3:0] a,
                        input logic [15:0] d);
        u_host.xfer({op, a, d}, rx);
        repeat (8) @(posedge mclk);
        #1;
    endtask

    task automatic waitIdle();
        int n;
        n = 0;
        repeat (3) @(posedge mclk);
        #1;
        while (rdyOe !== 1'b0 && n < 3000) begin
            @(posedge mclk);
            #1;
            n++;
        end
        chkW({9'h000, rdyOe}, 10'h000);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        rst_n = 1'b0;
        presetN = 1'b1;
        wpN = 1'b1;
        errTotal = 0;
        checkCount = 0;
        cycles = 0;
        repeat (12) @(posedge mclk);
        #1;
        rst_n = 1'b1;
        waitIdle();
        chkW(w1, WIPER_MID);
        chkW(w2, WIPER_MID);
        send(OP_WRITE, 4'h0, 16'hfd00);
        chkW(w1, 10'h100);
        chkW({9'h000, sdoOe}, 10'h000);
        chkW({8'h00, sdoO, rdyO}, 10'h000);
        send(OP_WRITE, 4'h1, 16'h03ff);
        chkF(rx, 24'hb0fd00);
        chkW(w2, WIPER_FULL);
        send(OP_INC, 4'h1, 16'h0000);
        chkW(w2, WIPER_FULL);
        send(OP_INC_ALL, 4'h0, 16'hffff);
        chkW(w1, 10'h101);
        send(OP_SHL, 4'h0, 16'h0000);
        chkW(w1, 10'h202);
        send(OP_SHL, 4'h0, 16'h0000);
        chkW(w1, WIPER_FULL);
        send(OP_SHL_ALL, 4'h0, 16'h0000);
        chkW(w2, WIPER_FULL);
        send(OP_SHR_ALL, 4'h0, 16'h0000);
        chkW(w1, 10'h1ff);
        chkW(w2, 10'h1ff);
        send(OP_WRITE, 4'h0, 16'h0000);
        send(OP_SHL, 4'h0, 16'h0000);
        chkW(w1, WIPER_ONE);
        send(OP_SHR, 4'h0, 16'h0000);
        send(OP_SHR, 4'h0, 16'h0000);
        chkW(w1, WIPER_ZERO);
        send(OP_DEC, 4'h0, 16'h0000);
        chkW(w1, WIPER_ZERO);
        send(OP_DEC_ALL, 4'h0, 16'h0000);
        chkW(w2, 10'h1fe);
        send(OP_NOP, 4'hf, 16'hffff);
        chkW(w2, 10'h1fe);
        send(OP_WRITE, 4'h0, 16'h0155);
        send(OP_SAVE, 4'h0, 16'h0000);
        chkW({9'h000, rdyOe}, 10'h001);
        send(OP_WRITE, 4'h0, 16'h0033);
        chkW(w1, 10'h155);
        waitIdle();
        send(OP_WRITE, 4'h0, 16'h0077);
        send(OP_RESTORE, 4'h0, 16'h0000);
        waitIdle();
        chkW(w1, 10'h155);
        chkW({9'h000, rdState}, 10'h001);
        send(OP_NOP, 4'h0, 16'h0000);
        chkW({9'h000, rdState}, 10'h000);
        send(OP_NVWRITE, 4'h5, 16'habcd);
        waitIdle();
        send(OP_NVWRITE, 4'hf, 16'h1234);
        waitIdle();
        send(OP_READ_NV, 4'h5, 16'h0000);
        waitIdle();
        send(OP_NOP, 4'h0, 16'h0000);
        chkF({8'h00, rx[15:0]}, 24'h00abcd);
        send(OP_READ_NV, 4'hf, 16'h0000);
        waitIdle();
        send(OP_NOP, 4'h0, 16'h0000);
        chkF({8'h00, rx[15:0]}, {8'h00, NV_FACTORY});
        send(OP_READ_WIPER, 4'h1, 16'h0000);
        waitIdle();
        send(OP_NOP, 4'h0, 16'h0000);
        chkF({8'h00, rx[15:0]}, 24'h0001fe);
        wpN = 1'b0;
        send(OP_WRITE, 4'h1, 16'h0000);
        chkW(w2, 10'h1fe);
        send(OP_NVWRITE, 4'h5, 16'h1234);
        chkW({9'h000, rdyOe}, 10'h000);
        send(OP_RELOAD_ALL, 4'h0, 16'h0000);
        waitIdle();
        chkW(w1, 10'h155);
        chkW(w2, WIPER_MID);
        send(OP_NOP, 4'h0, 16'h0000);
        wpN = 1'b1;
        send(OP_WRITE, 4'h0, 16'h0011);
        presetN = 1'b0;
        repeat (8) @(posedge mclk);
        #1;
        chkW(w1, WIPER_MID);
        presetN = 1'b1;
        waitIdle();
        chkW(w1, 10'h155);
        completeRun();
    end
endmodule // test_drsc_unit
